// >>> common/sfo_pkg.sv
// Shared constants for the serial flash security-page and status
// command ends: opcodes, status bit positions, timing, host registers.
// Assumes a 40 MHz system clock on both ends.
package sfo_pkg;
    // Command opcodes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_SPROG = 8'h42;
    localparam logic [7:0] OP_SREAD = 8'h48;
    // Security page address bytes
    localparam logic [7:0] ADDR_TOP = 8'h00;
    localparam logic [7:0] PAGE_FIRST = 8'h01;
    localparam logic [7:0] PAGE_LAST = 8'h03;
    localparam int OTP_BYTES = 1024;
    localparam int BUF_BYTES = 256;
    // Status byte one layout
    localparam int SR1_PROT_LOW = 7;
    localparam int SR1_SMALL_BLK = 6;
    localparam int SR1_TOP_BOT = 5;
    localparam int SR1_BP_LO = 2;
    localparam int SR1_LATCH = 1;
    localparam int SR1_BUSY = 0;
    localparam logic [5:0] SR1_RESET = 6'h00;
    // Status byte two lock bits (page one, two, three)
    localparam int SR2_LOCK1 = 3;
    // Self-timed program time
    localparam int CLK_NS = 25;
    localparam int PROG_TIME_NS = 700000;
    localparam int PROG_CYC = PROG_TIME_NS / CLK_NS;
    // Host register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TX = 8'h04;
    localparam logic [7:0] REG_RX = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_DIV = 8'h10;
    localparam int CTRL_CS = 0;
    localparam int STAT_SHIFT = 0;
    localparam int STAT_CS = 1;
    localparam logic [7:0] DIV_RESET = 8'h04;
    localparam logic [7:0] DIV_MIN = 8'h04;
    // Device command states
    typedef enum logic [3:0] {
        ST_CMD = 4'h0,
        ST_ADDR = 4'h1,
        ST_DUMMY = 4'h2,
        ST_READ = 4'h3,
        ST_STAT1 = 4'h4,
        ST_STAT2 = 4'h5,
        ST_PROG = 4'h6,
        ST_WRSR = 4'h7,
        ST_SKIP = 4'h8
    } sfo_state_t;
endpackage : sfo_pkg

// >>> common/sfo_link_if.sv
// Serial link between the flash host and the flash device.
// The serial output is open when its enable is high; a pull-up is
// modelled here so the host never samples an undriven level.
`timescale 1ns/1ps
interface sfo_link_if;
    logic cs_n; // Chip select, active low
    logic sclk; // Serial clock from the host
    logic mosi; // Host to device data
    logic miso; // Device output value
    logic miso_oe_n; // Device output enable, low while driving
    logic so_line; // Resolved serial output wire
    // Pulled high while the device lets go of the line
    assign so_line = miso_oe_n ? 1'b1 : miso;
    modport dev (input cs_n, input sclk, input mosi,
                 output miso, output miso_oe_n);
    modport host (output cs_n, output sclk, output mosi,
                  input so_line);
endinterface : sfo_link_if

// >>> rtl/sfo_flash_dev.sv
// Flash device end: security page program/read and status reads.
// Link pins arrive from the host's domain and are synchronised to clk.
// Operation
// - Security program reuses the 256-byte page buffer
// - Host sets write enable before program
// - Program: opcode, three address bytes, data
// - Address top 00, middle page 1-3
// - Read: opcode, address, dummy, then data
// - Read wraps from 3FF to 000
// - Chip select high ends read, releases output
// - Status reads accepted at any time
// - Opcode 05 repeats status byte one
// - Opcode 35 repeats status byte two
// - Each status pass shows live status
// - Chip select high ends status read
// - Byte one: protect, sector, top, levels
// - Bit 1 mirrors write enable latch
// - Bit 0 is busy flag
// - Write status changes bits 7-2 only
// - Latch clear rejects write-type commands
// - Program done or abort clears latch
// - Locked page refuses program
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module sfo_flash_dev #(
    parameter int PROG_CYCLES = sfo_pkg::PROG_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    sfo_link_if.dev link,
    input wire logic [7:0] status_two, // Live status byte two
    output logic [7:0] status_one, // Live status byte one
    output logic busy // Self-timed program running
);
    // The copy into the page takes one cycle per buffer byte
    if (PROG_CYCLES < sfo_pkg::BUF_BYTES) begin : g_bad_prog
        $error("PROG_CYCLES must cover the buffer copy");
    end

    localparam int CW = $clog2(PROG_CYCLES + 1);

    logic [1:0] cs_sy_r; // Chip select synchroniser
    logic cs_d_r; // Delayed for edge finding
    logic [1:0] sck_sy_r; // Serial clock synchroniser
    logic sck_d_r;
    logic [1:0] mosi_sy_r; // Data in synchroniser
    logic cs_act, cs_rise, sck_rise, sck_fall;
    logic [2:0] bit_cnt_r; // Bit within current byte
    logic [2:0] byte_idx_r; // Byte within frame, saturates at 7
    logic [7:0] shift_in_r;
    logic [7:0] byte_in; // Byte completing on this rise
    logic byte_done;
    sfo_pkg::sfo_state_t state_r;
    logic [7:0] cmd_r, top_r, page_r, wrsr_val_r;
    logic acc_r; // A write-type command was accepted
    logic addr_ok, lock_hit, whole;
    logic [9:0] rd_addr_r; // Security read pointer
    logic [2:0] out_cnt_r; // Bit within output byte
    logic [7:0] out_sh_r;
    logic miso_r, drive_r;
    logic out_state, out_load;
    logic [7:0] next_byte;
    logic [7:0] mem_r [sfo_pkg::OTP_BYTES]; // Security pages
    logic [7:0] buf_r [sfo_pkg::BUF_BYTES]; // Page buffer
    logic [sfo_pkg::BUF_BYTES-1:0] buf_vld_r; // Loaded buffer bytes
    logic [7:0] buf_ptr_r;
    logic got_data_r;
    logic prog_go, wrsr_go, aborted, prog_last;
    logic busy_r;
    logic [CW-1:0] prog_cnt_r;
    logic [1:0] prog_page_r;
    logic [5:0] st_r; // Writable bits 7..2 of status byte one
    logic wel_r;

    // Pin synchronisers; first stages feed only the second stages
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_sy_r <= 2'h3;
            cs_d_r <= 1'b1;
            sck_sy_r <= 2'h0;
            sck_d_r <= 1'b0;
            mosi_sy_r <= 2'h0;
        end else begin
            cs_sy_r <= {cs_sy_r[0], link.cs_n};
            cs_d_r <= cs_sy_r[1];
            sck_sy_r <= {sck_sy_r[0], link.sclk};
            sck_d_r <= sck_sy_r[1];
            mosi_sy_r <= {mosi_sy_r[0], link.mosi};
        end
    end

    assign cs_act = ~cs_sy_r[1];
    assign cs_rise = cs_sy_r[1] & ~cs_d_r;
    assign sck_rise = sck_sy_r[1] & ~sck_d_r & cs_act;
    assign sck_fall = ~sck_sy_r[1] & sck_d_r & cs_act;
    assign byte_in = {shift_in_r[6:0], mosi_sy_r[1]};
    assign byte_done = sck_rise & (bit_cnt_r == 3'h7);
    assign whole = (bit_cnt_r == 3'h0); // Frame ended on a byte edge

    // Bit and byte counting within a frame
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_r <= 3'h0;
            byte_idx_r <= 3'h0;
            shift_in_r <= 8'h00;
        end else if (!cs_act) begin
            bit_cnt_r <= 3'h0;
            byte_idx_r <= 3'h0;
        end else if (sck_rise) begin
            shift_in_r <= byte_in;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_done && byte_idx_r != 3'h7) begin
                byte_idx_r <= byte_idx_r + 3'h1;
            end
        end
    end

    // Page must be 1..3 for read and program; page 0 only by read wrap
    assign addr_ok = (top_r == sfo_pkg::ADDR_TOP)
        && (page_r <= sfo_pkg::PAGE_LAST)
        && (page_r >= sfo_pkg::PAGE_FIRST);
    assign lock_hit = (page_r >= sfo_pkg::PAGE_FIRST)
        && (page_r <= sfo_pkg::PAGE_LAST)
        && status_two[sfo_pkg::SR2_LOCK1 + int'(page_r[1:0]) - 1];

    // Command state machine; idles whenever chip select is high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= sfo_pkg::ST_CMD;
        end else if (!cs_act) begin
            state_r <= sfo_pkg::ST_CMD;
        end else if (byte_done) begin
            case (state_r)
                sfo_pkg::ST_CMD: begin
                    case (byte_in)
                        sfo_pkg::OP_RDSR1: begin
                            state_r <= sfo_pkg::ST_STAT1;
                        end
                        sfo_pkg::OP_RDSR2: begin
                            state_r <= sfo_pkg::ST_STAT2;
                        end
                        sfo_pkg::OP_SREAD: begin
                            state_r <= busy_r ? sfo_pkg::ST_SKIP
                                              : sfo_pkg::ST_ADDR;
                        end
                        sfo_pkg::OP_SPROG: begin
                            // Rejected without the latch
                            state_r <= (busy_r || !wel_r)
                                ? sfo_pkg::ST_SKIP : sfo_pkg::ST_ADDR;
                        end
                        sfo_pkg::OP_WRSR: begin
                            state_r <= (busy_r || !wel_r)
                                ? sfo_pkg::ST_SKIP : sfo_pkg::ST_WRSR;
                        end
                        default: begin
                            state_r <= sfo_pkg::ST_SKIP;
                        end
                    endcase
                end
                sfo_pkg::ST_ADDR: begin
                    // Third address byte decides read, program or skip
                    if (byte_idx_r == 3'h3) begin
                        if (!addr_ok) begin
                            state_r <= sfo_pkg::ST_SKIP;
                        end else if (cmd_r == sfo_pkg::OP_SREAD) begin
                            state_r <= sfo_pkg::ST_DUMMY;
                        end else begin
                            state_r <= sfo_pkg::ST_PROG;
                        end
                    end
                end
                sfo_pkg::ST_DUMMY: begin
                    state_r <= sfo_pkg::ST_READ;
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // Opcode and address byte capture
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_r <= 8'h00;
            top_r <= 8'h00;
            page_r <= 8'h00;
            wrsr_val_r <= 8'h00;
            acc_r <= 1'b0;
        end else if (!cs_act) begin
            acc_r <= 1'b0;
        end else if (byte_done) begin
            if (byte_idx_r == 3'h0) begin
                cmd_r <= byte_in;
                acc_r <= !busy_r && wel_r && (byte_in == sfo_pkg::OP_SPROG
                    || byte_in == sfo_pkg::OP_WRSR);
            end
            if (state_r == sfo_pkg::ST_ADDR && byte_idx_r == 3'h1) begin
                top_r <= byte_in;
            end
            if (state_r == sfo_pkg::ST_ADDR && byte_idx_r == 3'h2) begin
                page_r <= byte_in;
            end
            if (state_r == sfo_pkg::ST_WRSR && byte_idx_r == 3'h1) begin
                wrsr_val_r <= byte_in;
            end
        end
    end

    // Output byte source: live status on every pass, or page data
    assign out_state = (state_r == sfo_pkg::ST_STAT1)
        || (state_r == sfo_pkg::ST_STAT2) || (state_r == sfo_pkg::ST_READ);
    assign out_load = sck_fall && out_state && (out_cnt_r == 3'h0);
    always_comb begin
        case (state_r)
            sfo_pkg::ST_STAT1: next_byte = status_one;
            sfo_pkg::ST_STAT2: next_byte = status_two;
            default: next_byte = mem_r[rd_addr_r];
        endcase
    end

    // Read pointer; ten bits so the wrap costs no extra cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_addr_r <= 10'h000;
        end else if (byte_done && state_r == sfo_pkg::ST_ADDR
                     && byte_idx_r == 3'h3) begin
            rd_addr_r <= {page_r[1:0], byte_in};
        end else if (out_load && state_r == sfo_pkg::ST_READ) begin
            rd_addr_r <= rd_addr_r + 10'h001;
        end
    end

    // Serial output shifts on falling clock, most significant first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_cnt_r <= 3'h0;
            out_sh_r <= 8'h00;
            miso_r <= 1'b0;
            drive_r <= 1'b0;
        end else if (!cs_act) begin
            out_cnt_r <= 3'h0;
            drive_r <= 1'b0;
        end else if (sck_fall && out_state) begin
            drive_r <= 1'b1;
            out_cnt_r <= out_cnt_r + 3'h1;
            if (out_load) begin
                miso_r <= next_byte[7];
                out_sh_r <= {next_byte[6:0], 1'b0};
            end else begin
                miso_r <= out_sh_r[7];
                out_sh_r <= {out_sh_r[6:0], 1'b0};
            end
        end
    end

    // Releases as soon as chip select is seen high, even mid-byte
    assign link.miso = miso_r;
    assign link.miso_oe_n = ~(cs_act & drive_r);

    // Page buffer: cleared at opcode, then loaded from the low address
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buf_vld_r <= '0;
            buf_ptr_r <= 8'h00;
            got_data_r <= 1'b0;
        end else if (byte_done && state_r == sfo_pkg::ST_CMD
                     && byte_in == sfo_pkg::OP_SPROG && !busy_r && wel_r) begin
            buf_vld_r <= '0;
            got_data_r <= 1'b0;
        end else if (byte_done && state_r == sfo_pkg::ST_ADDR
                     && byte_idx_r == 3'h3) begin
            buf_ptr_r <= byte_in;
        end else if (byte_done && state_r == sfo_pkg::ST_PROG) begin
            buf_vld_r[buf_ptr_r] <= 1'b1;
            buf_ptr_r <= buf_ptr_r + 8'h01;
            got_data_r <= 1'b1;
        end
    end

    // Buffer data carries no reset; its valid bits guard it
    always_ff @(posedge clk) begin
        if (byte_done && state_r == sfo_pkg::ST_PROG) begin
            buf_r[buf_ptr_r] <= byte_in;
        end
    end

    // Commit and abort decisions taken on chip select rising
    assign prog_go = cs_rise && state_r == sfo_pkg::ST_PROG && whole
        && got_data_r && !lock_hit;
    assign wrsr_go = cs_rise && state_r == sfo_pkg::ST_WRSR && whole
        && byte_idx_r >= 3'h2;
    assign aborted = cs_rise && acc_r && !prog_go && !wrsr_go;
    assign prog_last = busy_r && prog_cnt_r == CW'(PROG_CYCLES - 1);

    // Self-timed program; the copy runs in the first buffer-size cycles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_r <= 1'b0;
            prog_cnt_r <= '0;
            prog_page_r <= 2'h0;
        end else if (prog_go) begin
            busy_r <= 1'b1;
            prog_cnt_r <= '0;
            prog_page_r <= page_r[1:0];
        end else if (busy_r) begin
            prog_cnt_r <= prog_cnt_r + CW'(1);
            if (prog_last) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Pages come up erased; programming can only clear bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < sfo_pkg::OTP_BYTES; i++) begin
                mem_r[i] <= 8'hff;
            end
        end else if (busy_r && prog_cnt_r < CW'(sfo_pkg::BUF_BYTES)
                     && buf_vld_r[prog_cnt_r[7:0]]) begin
            mem_r[{prog_page_r, prog_cnt_r[7:0]}] <=
                mem_r[{prog_page_r, prog_cnt_r[7:0]}]
                & buf_r[prog_cnt_r[7:0]];
        end
    end

    // Write enable latch and the writable status bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wel_r <= 1'b0;
            st_r <= sfo_pkg::SR1_RESET;
        end else begin
            if (cs_rise && whole && byte_idx_r == 3'h1 && !busy_r) begin
                if (cmd_r == sfo_pkg::OP_WREN) begin
                    wel_r <= 1'b1;
                end else if (cmd_r == sfo_pkg::OP_WRDI) begin
                    wel_r <= 1'b0;
                end
            end
            if (wrsr_go) begin
                st_r <= wrsr_val_r[7:2];
                wel_r <= 1'b0;
            end
            if (aborted || prog_last) begin
                wel_r <= 1'b0;
            end
        end
    end

    // Protect, sector, top/bottom, levels, latch copy, busy
    assign status_one = {st_r, wel_r, busy_r};
    assign busy = busy_r;
endmodule : sfo_flash_dev

// >>> rtl/sfo_spi_host.sv
// Flash host end: an AHB-Lite slave whose registers let software
// frame commands with chip select and shift one byte at a time.
// Assumes a single AHB-Lite master and the device on the link.
`timescale 1ns/1ps
module sfo_spi_host (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    sfo_link_if.host link
);
    logic wr_pend_r; // Write data phase pending
    logic [7:0] a_r; // Latched write address
    logic [31:0] hrdata_r;
    logic [31:0] rd_val;
    logic cs_en_r; // Software holds chip select low
    logic [7:0] div_r; // Half period in clk cycles
    logic active_r, sclk_r, mosi_r;
    logic [7:0] hcnt_r, tx_sh_r, rx_sh_r;
    logic [2:0] bits_r;
    logic [1:0] miso_sy_r; // Serial input synchroniser
    logic start;

    // Zero wait states, always OKAY; hsize is word only
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // Read value for an address phase address
    always_comb begin
        if (haddr[7:0] == sfo_pkg::REG_CTRL) begin
            rd_val = {31'h0, cs_en_r};
        end else if (haddr[7:0] == sfo_pkg::REG_RX) begin
            rd_val = {24'h0, rx_sh_r};
        end else if (haddr[7:0] == sfo_pkg::REG_STAT) begin
            rd_val = {30'h0, cs_en_r, active_r};
        end else if (haddr[7:0] == sfo_pkg::REG_DIV) begin
            rd_val = {24'h0, div_r};
        end else begin
            rd_val = 32'h0; // Unmapped and write-only read zero
        end
    end

    // Address phase capture; read data registered for the data phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_r <= 1'b0;
            a_r <= 8'h00;
            hrdata_r <= 32'h0;
        end else if (hready) begin
            wr_pend_r <= hsel && htrans[1] && hwrite;
            a_r <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                hrdata_r <= rd_val;
            end
        end
    end

    // Control registers written in the data phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_en_r <= 1'b0;
            div_r <= sfo_pkg::DIV_RESET;
        end else if (wr_pend_r) begin
            if (a_r == sfo_pkg::REG_CTRL) begin
                cs_en_r <= hwdata[sfo_pkg::CTRL_CS];
            end else if (a_r == sfo_pkg::REG_DIV) begin
                // Too short a half period beats the device's sync delay
                div_r <= (hwdata[7:0] < sfo_pkg::DIV_MIN)
                    ? sfo_pkg::DIV_MIN : hwdata[7:0];
            end
        end
    end

    // A byte write while shifting or deselected is dropped
    assign start = wr_pend_r && a_r == sfo_pkg::REG_TX
        && !active_r && cs_en_r;

    // Serial input synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            miso_sy_r <= 2'h3;
        end else begin
            miso_sy_r <= {miso_sy_r[0], link.so_line};
        end
    end

    // Byte engine: mode 0, data out on fall, sampled before the fall
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            active_r <= 1'b0;
            sclk_r <= 1'b0;
            mosi_r <= 1'b0;
            hcnt_r <= 8'h00;
            tx_sh_r <= 8'h00;
            rx_sh_r <= 8'h00;
            bits_r <= 3'h0;
        end else if (!cs_en_r) begin
            active_r <= 1'b0; // Deselect cuts a byte short
            sclk_r <= 1'b0;
        end else if (start) begin
            active_r <= 1'b1;
            tx_sh_r <= hwdata[7:0];
            mosi_r <= hwdata[7];
            hcnt_r <= 8'h00;
            bits_r <= 3'h0;
        end else if (active_r) begin
            if (hcnt_r == div_r - 8'h01) begin
                hcnt_r <= 8'h00;
                if (!sclk_r) begin
                    sclk_r <= 1'b1;
                end else begin
                    sclk_r <= 1'b0;
                    rx_sh_r <= {rx_sh_r[6:0], miso_sy_r[1]};
                    tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                    mosi_r <= tx_sh_r[6];
                    bits_r <= bits_r + 3'h1;
                    if (bits_r == 3'h7) begin
                        active_r <= 1'b0;
                    end
                end
            end else begin
                hcnt_r <= hcnt_r + 8'h01;
            end
        end
    end

    // Software frames each command with chip select
    assign link.cs_n = ~cs_en_r;
    assign link.sclk = sclk_r;
    assign link.mosi = mosi_r;
endmodule : sfo_spi_host

// >>> bench/sfo_props.sv
// Checker for the link and the device status outputs.
// Assumes one clk domain, rstn async active low.
`timescale 1ns/1ps
module sfo_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic miso,
    input wire logic miso_oe_n,
    input wire logic [7:0] status_one,
    input wire logic busy
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_oe_release: assert property (
        cs_n [*6] |-> miso_oe_n)
        else $error("output still driven after deselect");
    a_opcode_quiet: assert property (
        $fell(cs_n) |-> miso_oe_n [*8])
        else $error("output driven during opcode");
    a_out_steady: assert property (
        (!miso_oe_n && $changed(miso)) |-> !sclk)
        else $error("output moved while clock high");
    // Latch stays set while the program runs; it clears only at the end
    a_busy_shown: assert property (
        $rose(busy) |-> ##[0:2] (status_one[1:0] == 2'h3))
        else $error("busy or latch bit missing");
    a_busy_clear: assert property (
        $fell(busy) |-> ##[0:2] (status_one[1:0] == 2'h0))
        else $error("busy or latch left set");
    a_start_on_cs: assert property (
        $rose(busy) |-> (cs_n && $past(status_one[1])))
        else $error("program began without latch or frame end");
    a_busy_holds: assert property (
        $rose(busy) |-> busy [*8])
        else $error("busy dropped early");
    a_latch_frame: assert property (
        $rose(status_one[1]) |-> cs_n)
        else $error("latch set inside a frame");
endmodule : sfo_props

// >>> bench/tb_spi_flash_otp_page_and_status_commands.sv
// Bench: software drives the host over AHB-Lite, device answers.
// Assumes both ends meet in sfo_link_if.
`timescale 1ns/1ps
module tb_spi_flash_otp_page_and_status_commands;
    logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic hreadyout, hresp, busy;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [7:0] status_two = 8'h00, status_one;
    logic [7:0] rx[$]; // Bytes seen during the last frame
    int err_count = 0, compares = 0;
    sfo_link_if lnk ();
    // Short program time keeps the run brief
    sfo_flash_dev #(.PROG_CYCLES(300)) i_sfo_flash_dev (.clk(clk),
        .rstn(rstn), .link(lnk), .status_two(status_two),
        .status_one(status_one), .busy(busy));
    sfo_spi_host i_sfo_spi_host (.clk(clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .link(lnk));
    sfo_props i_sfo_props (.clk(clk), .rstn(rstn), .cs_n(lnk.cs_n),
        .sclk(lnk.sclk), .miso(lnk.miso), .miso_oe_n(lnk.miso_oe_n),
        .status_one(status_one), .busy(busy));
    initial forever #12.5 clk = ~clk;
    task print_verdict;
        $display("compares=%0d errors=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Every wait counts here, so a hang ends the run
    task bound(inout int n);
        n++;
        if (n > 500) begin
            err_count++;
            $display("Error %0t: wait timed out", $time);
            print_verdict();
        end
    endtask : bound
    task rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            bound(n);
        end while (hreadyout !== 1'b1);
    endtask : rdy
    // Single word transfer; read data lands in q
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= {24'h0, a};
        hwrite <= w;
        hsel <= 1'b1;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        q = hrdata;
    endtask : ahb
    task xfer(input logic [7:0] b);
        int n;
        n = 0;
        ahb(1'b1, sfo_pkg::REG_TX, {24'h0, b});
        do begin
            ahb(1'b0, sfo_pkg::REG_STAT, 32'h0);
            bound(n);
        end while (q[sfo_pkg::STAT_SHIFT] !== 1'b0);
        ahb(1'b0, sfo_pkg::REG_RX, 32'h0);
        rx.push_back(q[7:0]);
    endtask : xfer
    // Gap after deselect lets the device see chip select high
    task frame(input logic [7:0] b[$]);
        rx = {};
        ahb(1'b1, sfo_pkg::REG_CTRL, 32'h1);
        foreach (b[i]) xfer(b[i]);
        ahb(1'b1, sfo_pkg::REG_CTRL, 32'h0);
        repeat (8) @(posedge clk);
    endtask : frame
    task t_status;
        ahb(1'b0, 8'h20, 32'h0);
        chk(q[7:0], 8'h00);
        chk({7'h00, hresp}, 8'h00);
        frame({8'h06});
        frame({8'h05, 8'h00, 8'h00});
        chk(rx[1], 8'h02);
        chk(rx[2], 8'h02);
        frame({8'h04});
        status_two <= 8'h20;
        frame({8'h35, 8'h00, 8'h00});
        chk(rx[2], 8'h20);
        frame({8'h42, 8'h00, 8'h01, 8'h00, 8'h00});
        frame({8'h05, 8'h00});
        chk(rx[1], 8'h00);
    endtask : t_status
    task t_lock;
        status_two <= 8'h08;
        frame({8'h06});
        frame({8'h42, 8'h00, 8'h01, 8'h00, 8'h00});
        frame({8'h05, 8'h00});
        chk(rx[1], 8'h00);
    endtask : t_lock
    task t_prog;
        int n;
        n = 0;
        status_two <= 8'h00;
        frame({8'h06});
        frame({8'h42, 8'h00, 8'h03, 8'hff, 8'h5a, 8'hc3});
        frame({8'h05, 8'h00});
        chk(rx[1] & 8'h01, 8'h01);
        do begin
            frame({8'h05, 8'h00});
            bound(n);
        end while (rx[1][0] !== 1'b0);
        chk(rx[1], 8'h00);
        frame({8'h48, 8'h00, 8'h03, 8'hff, 8'h00, 8'h00, 8'h00});
        chk(rx[5], 8'h5a);
        chk(rx[6], 8'hff);
        frame({8'h48, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00});
        chk(rx[5], 8'hc3);
        // Non-zero top byte is refused, so the line stays pulled high
        frame({8'h48, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00});
        chk(rx[5], 8'hff);
        // Write status sets bits 7..2 only and clears the latch
        frame({8'h06});
        frame({8'h01, 8'hff});
        frame({8'h05, 8'h00});
        chk(rx[1], 8'hfc);
    endtask : t_prog
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_status();
        t_lock();
        t_prog();
        print_verdict();
    end
endmodule : tb_spi_flash_otp_page_and_status_commands
